// [capture_slice_defines.svh]
`ifndef CAPTURE_SLICE_DEFINES_SVH
`define CAPTURE_SLICE_DEFINES_SVH

// register byte addresses (byte address = index * 4)
`define ADDR_CTRL        8'h00
`define ADDR_SEL         8'h04
`define ADDR_CAP0        8'h08
`define ADDR_CAP1        8'h0C
`define ADDR_CAP2        8'h10
`define ADDR_CAP3        8'h14
`define ADDR_FIFO0       8'h18
`define ADDR_FIFO1       8'h1C
`define ADDR_STATUS      8'h20
`define ADDR_TIMER       8'h24

// control register fields
`define CTRL_SHARED_BIT  0
`define CTRL_CONT_BIT    1
`define CTRL_EXT_BIT     2
`define CTRL_RUN_BIT     3
`define CTRL_RESET       4'h0

// select register fields
`define SEL0_LSB         0
`define SEL1_LSB         4
`define EDGE0_LSB        8
`define EDGE1_LSB        10
`define SEL_RESET        12'h000

// edge modes
`define EDGE_NONE        2'h0
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
`define EDGE_BOTH        2'h3

// fifo read data fields
`define FIFO_LOST_BIT    16
`define FIFO_VALID_BIT   17

// status register fields
`define STAT_FULL_LSB    0
`define STAT_ST_BIT      4
`define STAT_LOST0_BIT   5
`define STAT_LOST1_BIT   6
`define STAT_CMP_BIT     7
`define STAT_PER_BIT     8

`define TIMER_ZERO       16'h0000
`define TIMER_ONE        16'h0001
`define PERIOD_RESET     16'hFFFF
`define SEL_OFF          4'h0

`endif

// [capture_slice_pkg.sv]
package capture_slice_pkg;
    typedef logic [15:0] timer_t;
    typedef logic [1:0]  edge_t;
endpackage

// [timer_slice_capture_fifo.sv]
`timescale 1ns/1ps
`include "capture_slice_defines.svh"
// Summary of operation
// R1: nonzero trigger select enables capture mode
// R2: capture regs 0/1 disable compare channel
// R3: capture regs 2/3 disable period control
// R4: triggers act on selected input edge
// R5: shared event: software programs trigger 1
// R6: trigger 1 loads reg3, shifts to reg2
// R7: trigger 0 loads reg1, shifts to reg0
// R8: each capture sets register full flag
// R9: reads clear that register's full flag
// R10: two-register chain gated by full flags
// R11: continuous capture ignores full-flag locking
// R12: trigger 1 capture: counter wraps 16 bits
// R13: status sets on capture, clears at zero
// R14: shared event chains all four registers
// R15: four-chain gating; continuous overrides it
// R16: extended read-back returns oldest unread value
// R17: depth-4 fifo when shared and trigger1
// R18: else two depth-2 fifos, locations 0/1
// R19: lost bit set on event while full
// R20: lost bit cleared by next fifo read
// R21: extended mode: only fifo reads clear flags
// R22: reset clears full and lost flags
module timer_slice_capture_fifo
    import capture_slice_pkg::*;
#(
    parameter int IN_COUNT = 16
)(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [IN_COUNT-1:0] event_in,
    input  wire logic [7:0]          addr,
    input  wire logic [31:0]         wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic [31:0]              rdata,
    output logic                     slice_status_bit,
    output logic                     capture_mode,
    output logic                     compare_avail,
    output logic                     period_avail
);
    if (IN_COUNT < 1 || IN_COUNT > 16)
    begin
        $error("IN_COUNT must be 1..16");
    end

    logic [3:0]  ctrl_q;
    logic [11:0] sel_q;
    timer_t      timer_q;
    timer_t      period_q;
    timer_t      cap_q [4];
    logic [3:0]  full_q;
    logic [1:0]  lost_q;
    logic        st_q;
    logic [31:0] rdata_q;

    // three-stage synchroniser per input
    logic [IN_COUNT-1:0] s1_q;
    logic [IN_COUNT-1:0] s2_q;
    logic [IN_COUNT-1:0] s3_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= event_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    wire logic [3:0] sel0   = sel_q[`SEL0_LSB +: 4];
    wire logic [3:0] sel1   = sel_q[`SEL1_LSB +: 4];
    wire edge_t      em0    = sel_q[`EDGE0_LSB +: 2];
    wire edge_t      em1    = sel_q[`EDGE1_LSB +: 2];
    wire logic       shared = ctrl_q[`CTRL_SHARED_BIT];
    wire logic       cont   = ctrl_q[`CTRL_CONT_BIT];
    wire logic       ext    = ctrl_q[`CTRL_EXT_BIT];
    wire logic       run    = ctrl_q[`CTRL_RUN_BIT];

    // select value n picks input n-1; zero disables the trigger
    function automatic logic edge_hit(input logic [3:0] s, input edge_t m,
                                      input logic [IN_COUNT-1:0] now,
                                      input logic [IN_COUNT-1:0] old);
        logic a;
        logic b;
        a = 1'b0;
        b = 1'b0;
        if (s != `SEL_OFF && 32'(s) <= IN_COUNT)
        begin
            a = now[s - 4'h1];
            b = old[s - 4'h1];
        end
        case (m)
            `EDGE_RISE: edge_hit = a & ~b;
            `EDGE_FALL: edge_hit = ~a & b;
            `EDGE_BOTH: edge_hit = a ^ b;
            default:    edge_hit = 1'b0;
        endcase
    endfunction

    wire logic mode0 = (sel0 != `SEL_OFF) && !shared;                 // [R1] [R5]
    wire logic mode1 = (sel1 != `SEL_OFF);                            // [R1]

    // edges counted once stages two and three agree
    logic [IN_COUNT-1:0] prev_q;
    logic [IN_COUNT-1:0] stable;
    assign stable = (s2_q & s3_q) | (prev_q & (s2_q ^ s3_q));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= '0;
        else
            prev_q <= stable;
    end
    wire logic t0 = mode0 && edge_hit(sel0, em0, stable, prev_q);     // [R4]
    wire logic t1 = mode1 && edge_hit(sel1, em1, stable, prev_q);     // [R4]

    // register reads that release full flags
    wire logic rd_cap0 = rd && addr == `ADDR_CAP0;
    wire logic rd_cap1 = rd && addr == `ADDR_CAP1;
    wire logic rd_cap2 = rd && addr == `ADDR_CAP2;
    wire logic rd_cap3 = rd && addr == `ADDR_CAP3;
    wire logic rd_f0   = rd && addr == `ADDR_FIFO0;
    wire logic rd_f1   = rd && addr == `ADDR_FIFO1;

    // fifo head: oldest full register of the structure
    logic        deep;
    logic [1:0]  head0;
    logic        has0;
    logic [1:0]  head1;
    logic        has1;
    assign deep = shared && mode1;                                    // [R17]
    always_comb
    begin
        has0  = full_q[0] | full_q[1];                                // [R18]
        head0 = full_q[0] ? 2'h0 : 2'h1;
        has1  = 1'b1;
        head1 = 2'h3;
        if (deep && full_q[0])
            head1 = 2'h0;                                             // [R16]
        else if (deep && full_q[1])
            head1 = 2'h1;
        else if (full_q[2])
            head1 = 2'h2;
        else if (!full_q[3])
            has1 = 1'b0;
    end

    // flag clears from reads
    logic [3:0] clr;
    always_comb
    begin
        clr = 4'h0;
        if (!ext)                                                     // [R21]
            clr = {rd_cap3, rd_cap2, rd_cap1, rd_cap0};               // [R9]
        else
        begin
            if (rd_f0 && has0 && !deep)
                clr[head0] = 1'b1;                                    // [R9]
            if (rd_f1 && has1)
                clr[head1] = 1'b1;                                    // [R9]
        end
    end

    // load enables per register
    logic [3:0] ld;
    always_comb
    begin
        ld = 4'h0;
        if (deep)
        begin
            if (t1)                                                   // [R14] [R15]
            begin
                ld[3] = cont || !(&full_q);
                ld[2] = cont || (full_q[3] && !(&full_q[2:0]));
                ld[1] = cont || (full_q[2] && !(&full_q[1:0]));
                ld[0] = cont || (full_q[1] && !full_q[0]);
            end
        end
        else
        begin
            if (t1)                                                   // [R6] [R10] [R11]
            begin
                ld[3] = cont || !(full_q[3] && full_q[2]);
                ld[2] = cont || (full_q[3] && !full_q[2]);
            end
            if (t0)                                                   // [R7] [R10] [R11]
            begin
                ld[1] = cont || !(full_q[1] && full_q[0]);
                ld[0] = cont || (full_q[1] && !full_q[0]);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
                cap_q[i] <= `TIMER_ZERO;
        end
        else
        begin
            if (ld[3])
                cap_q[3] <= timer_q;                                  // [R6]
            if (ld[2])
                cap_q[2] <= cap_q[3];                                 // [R6]
            if (ld[1])
                cap_q[1] <= deep ? cap_q[2] : timer_q;                // [R7] [R14]
            if (ld[0])
                cap_q[0] <= cap_q[1];                                 // [R7]
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            full_q <= 4'h0;                                           // [R22]
        else
            full_q <= (full_q & ~clr) | ld;                           // [R8]
    end

    logic full_s0;
    logic full_s1;
    assign full_s0 = &full_q[1:0];
    assign full_s1 = deep ? &full_q : &full_q[3:2];
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lost_q <= 2'b00;                                          // [R22]
        else
        begin
            if (t0 && full_s0)
                lost_q[0] <= 1'b1;                                    // [R19]
            else if (rd_f0)
                lost_q[0] <= 1'b0;                                    // [R20]
            if (t1 && full_s1)
                lost_q[1] <= 1'b1;                                    // [R19]
            else if (rd_f1)
                lost_q[1] <= 1'b0;                                    // [R20]
        end
    end

    // slice counter: full range when trigger 1 captures
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            timer_q <= `TIMER_ZERO;
        else if (run)
        begin
            if (!mode1 && timer_q >= period_q)                        // [R12]
                timer_q <= `TIMER_ZERO;
            else
                timer_q <= timer_q + `TIMER_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= 1'b0;
        else if (t0 || t1)
            st_q <= 1'b1;                                             // [R13]
        else if ((mode0 || mode1) && timer_q == `TIMER_ZERO)
            st_q <= 1'b0;                                             // [R13]
    end

    // software registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q   <= `CTRL_RESET;
            sel_q    <= `SEL_RESET;
            period_q <= `PERIOD_RESET;
        end
        else if (wr)
        begin
            if (addr == `ADDR_CTRL)
                ctrl_q <= wdata[3:0];
            if (addr == `ADDR_SEL)
                sel_q <= wdata[11:0];
            if (addr == `ADDR_TIMER && !mode1)                        // [R3]
                period_q <= wdata[15:0];
        end
    end

    logic [31:0] rd_d;
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (addr)
            `ADDR_CTRL:  rd_d[3:0]   = ctrl_q;
            `ADDR_SEL:   rd_d[11:0]  = sel_q;
            `ADDR_CAP0:  rd_d[15:0]  = cap_q[0];
            `ADDR_CAP1:  rd_d[15:0]  = cap_q[1];
            `ADDR_CAP2:  rd_d[15:0]  = cap_q[2];
            `ADDR_CAP3:  rd_d[15:0]  = cap_q[3];
            `ADDR_FIFO0:
            begin
                rd_d[15:0]            = cap_q[head0];
                rd_d[`FIFO_LOST_BIT]  = lost_q[0];
                rd_d[`FIFO_VALID_BIT] = has0 && !deep;
            end
            `ADDR_FIFO1:
            begin
                rd_d[15:0]            = cap_q[head1];                 // [R16]
                rd_d[`FIFO_LOST_BIT]  = lost_q[1];
                rd_d[`FIFO_VALID_BIT] = has1;
            end
            `ADDR_STATUS:
            begin
                rd_d[`STAT_FULL_LSB +: 4] = full_q;
                rd_d[`STAT_ST_BIT]        = st_q;
                rd_d[`STAT_LOST0_BIT]     = lost_q[0];
                rd_d[`STAT_LOST1_BIT]     = lost_q[1];
                rd_d[`STAT_CMP_BIT]       = !(mode0 || deep);         // [R2]
                rd_d[`STAT_PER_BIT]       = !mode1;                   // [R3]
            end
            `ADDR_TIMER: rd_d[15:0]  = timer_q;
            default:     rd_d        = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h0000_0000;
        else
            rdata_q <= rd ? rd_d : 32'h0000_0000;
    end

    logic cm_q;
    logic ca_q;
    logic pa_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cm_q <= 1'b0;
            ca_q <= 1'b1;
            pa_q <= 1'b1;
        end
        else
        begin
            cm_q <= mode0 || mode1;                                   // [R1]
            ca_q <= !(mode0 || deep);                                 // [R2]
            pa_q <= !mode1;                                           // [R3]
        end
    end

    assign rdata            = rdata_q;
    assign slice_status_bit = st_q;
    assign capture_mode     = cm_q;
    assign compare_avail    = ca_q;
    assign period_avail     = pa_q;
endmodule

// [slice_capture_properties.sv]
`timescale 1ns/1ps
`include "capture_slice_defines.svh"
module slice_capture_properties #(
    parameter int IN_COUNT = 16
)(
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic [IN_COUNT-1:0] event_in,
    input wire logic [7:0]          addr,
    input wire logic [31:0]         wdata,
    input wire logic                wr,
    input wire logic                rd,
    input wire logic [31:0]         rdata,
    input wire logic                slice_status_bit,
    input wire logic                capture_mode,
    input wire logic                compare_avail,
    input wire logic                period_avail
);
    logic [IN_COUNT-1:0] prev_q;
    logic [3:0]          quiet_q;
    // cycles since the trigger inputs last moved, saturating
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q  <= '0;
            quiet_q <= 4'h0;
        end
        else
        begin
            prev_q <= event_in;
            if (event_in != prev_q)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hF)
                quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    mode_set_a: assert property (
        wr && addr == `ADDR_SEL && wdata[7:0] != 8'h00 |-> ##[1:2] capture_mode)
        else $error("capture mode not entered");
    mode_clear_a: assert property (
        wr && addr == `ADDR_SEL && wdata[7:0] == 8'h00 |-> ##[1:2] !capture_mode)
        else $error("capture mode not left");
    period_lock_a: assert property (
        wr && addr == `ADDR_SEL && wdata[7:4] != 4'h0 |-> ##[1:2] !period_avail)
        else $error("period still available");
    avail_idle_a: assert property (
        !capture_mode |-> compare_avail && period_avail)
        else $error("channel lost outside capture mode");
    read_quiet_a: assert property (
        !rd |=> rdata == 32'h0000_0000)
        else $error("read data without a read");
    rdata_width_a: assert property (
        rdata[31:18] == 14'h0000)
        else $error("read data upper bits set");
    cap_width_a: assert property (
        rd && addr >= `ADDR_CAP0 && addr <= `ADDR_CAP3 |=> rdata[31:16] == 16'h0000)
        else $error("capture read wider than timer");
    edge_cause_a: assert property (
        $rose(slice_status_bit) |-> capture_mode && quiet_q >= 4'h2 && quiet_q <= 4'h8)
        else $error("status set without an input edge");
    lost_clear_a: assert property (
        (rd && addr == `ADDR_FIFO1 && quiet_q > 4'h8) ##1 (rd && addr == `ADDR_FIFO1)
        |=> !rdata[`FIFO_LOST_BIT])
        else $error("lost bit survived a read");
endmodule
bind timer_slice_capture_fifo slice_capture_properties #(.IN_COUNT(IN_COUNT)) u_props (
    .clk(clk), .rst_n(rst_n), .event_in(event_in), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .slice_status_bit(slice_status_bit),
    .capture_mode(capture_mode), .compare_avail(compare_avail),
    .period_avail(period_avail));

// [trigger_source.sv]
`timescale 1ns/1ps
module trigger_source #(
    parameter int IN_COUNT = 16
)(
    input  wire logic                clk,
    output logic      [IN_COUNT-1:0] event_in
);
    initial event_in = '0;
    // level held long enough to pass the synchroniser
    task automatic drive(input int idx, input logic lvl);
        @(posedge clk);
        event_in[idx] <= lvl;
        repeat (10) @(posedge clk);
    endtask
    task automatic pulse(input int idx);
        drive(idx, 1'b1);
        drive(idx, 1'b0);
    endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
`include "capture_slice_defines.svh"
module tb
    import capture_slice_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic [15:0] event_in;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        slice_status_bit;
    logic        capture_mode;
    logic        compare_avail;
    logic        period_avail;
    int          num_errors;
    int          checks_done;
    logic [31:0] ctl;
    logic [31:0] d0;
    logic [31:0] d1;
    timer_t      v [5];
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    timer_slice_capture_fifo #(.IN_COUNT(16)) DUT (
        .clk(clk), .rst_n(rst_n), .event_in(event_in), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .slice_status_bit(slice_status_bit),
        .capture_mode(capture_mode), .compare_avail(compare_avail),
        .period_avail(period_avail));
    trigger_source #(.IN_COUNT(16)) src (.clk(clk), .event_in(event_in));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    // two reads back to back
    task automatic rd_two(input logic [7:0] a, output logic [31:0] x, output logic [31:0] y);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        x = rdata;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        y = rdata;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, d0);
        chk(name, exp, d0);
    endtask
    // run the timer briefly, freeze it, then trigger a capture of the frozen value
    task automatic cap(input int idx, output timer_t t);
        wr_reg(`ADDR_CTRL, ctl | 32'h0000_0008);
        repeat (7) @(posedge clk);
        wr_reg(`ADDR_CTRL, ctl);
        rd_reg(`ADDR_TIMER, d0);
        t = d0[15:0];
        src.pulse(idx);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        ctl = 32'h0000_0000;
        num_errors = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("status", `ADDR_STATUS, 32'h0000_0180);
        wr_reg(`ADDR_SEL, 32'h0000_0000);
        wr_reg(`ADDR_SEL, 32'h0000_0921);
        repeat (3) @(negedge clk);
        chk("mode", 1, capture_mode);
        chk("cmp_avail", 0, compare_avail);
        chk("per_avail", 0, period_avail);
        wr_reg(`ADDR_TIMER, 32'h0000_0005);
        cap(0, v[0]);
        cap(0, v[1]);
        chk("wrap", 1, v[0] > 16'h0005);
        rd_chk("full2", `ADDR_STATUS, 32'h0000_0013);
        cap(0, v[2]);
        rd_chk("cap0", `ADDR_CAP0, {16'h0000, v[0]});
        rd_chk("full_rd", `ADDR_STATUS, 32'h0000_0032);
        rd_chk("cap1", `ADDR_CAP1, {16'h0000, v[1]});
        chk("st", 1, slice_status_bit);
        cap(1, v[3]);
        rd_chk("fall_only", `ADDR_STATUS, 32'h0000_0038);
        rd_chk("cap3", `ADDR_CAP3, {16'h0000, v[3]});
        cap(1, v[4]);
        rd_chk("cap2", `ADDR_CAP2, 32'h0000_0000);
        cap(1, v[2]);
        rd_chk("cap2b", `ADDR_CAP2, {16'h0000, v[4]});
        rd_chk("cap3b", `ADDR_CAP3, {16'h0000, v[2]});
        ctl = 32'h0000_0002;
        for (int i = 0; i < 3; i++)
            cap(0, v[i]);
        rd_chk("cont1", `ADDR_CAP1, {16'h0000, v[2]});
        rd_chk("cont0", `ADDR_CAP0, {16'h0000, v[1]});
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        ctl = 32'h0000_0005;
        wr_reg(`ADDR_SEL, 32'h0000_0420);
        for (int i = 0; i < 5; i++)
            cap(1, v[i]);
        rd_chk("chain0", `ADDR_CAP0, {16'h0000, v[0]});
        rd_reg(`ADDR_STATUS, d0);
        chk("full4", 32'h0000_000F, d0 & 32'h0000_000F);
        rd_two(`ADDR_FIFO1, d0, d1);
        chk("fifo_a", {16'h0003, v[0]}, d0);
        chk("fifo_b", {16'h0002, v[1]}, d1);
        rd_two(`ADDR_FIFO1, d0, d1);
        chk("fifo_c", {16'h0002, v[2]}, d0);
        chk("fifo_d", {16'h0002, v[3]}, d1);
        rd_reg(`ADDR_FIFO1, d0);
        chk("empty1", 0, d0[`FIFO_VALID_BIT]);
        rd_reg(`ADDR_FIFO0, d0);
        chk("empty0", 0, d0[`FIFO_VALID_BIT]);
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule
